// *** hdl/tbcs_clk_mux.sv ***
// Per-timer count source multiplexer with runt-free source switching
module tbcs_clk_mux (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Requested selection
    input wire logic [2:0] reqSel,
    input wire logic reqOpt,
    input wire logic [1:0] reqAlt,
    // Source ticks
    input wire logic baseTick,
    input wire logic div8Tick,
    input wire logic div32Tick,
    input wire logic div64Tick,
    input wire logic slowOscTick,
    input wire logic sub32kTick,
    input wire logic [3:0] altTick,
    // Timer state and results
    input wire logic timerRun,
    output logic countTick,
    output logic [2:0] appliedSel,
    output logic appliedOpt
);
    // ----------------------------------------------------------------
    // Source selection
    // ----------------------------------------------------------------
    logic [1:0] appliedAlt_q;
    logic internalTick;
    logic curTick;
    logic takeNew;
    // Reserved codes give no ticks at all rather than an arbitrary source
    always_comb begin
        case (tbcs_pkg::tbcs_src_e'(appliedSel))
            tbcs_pkg::SRC_BASE: internalTick = baseTick;
            tbcs_pkg::SRC_DIV8: internalTick = div8Tick;
            tbcs_pkg::SRC_DIV32: internalTick = div32Tick;
            tbcs_pkg::SRC_DIV64: internalTick = div64Tick;
            tbcs_pkg::SRC_SLOW_OSC: internalTick = slowOscTick;
            tbcs_pkg::SRC_SUB32K: internalTick = sub32kTick;
            default: internalTick = 1'b0;
        endcase
    end
    assign curTick = appliedOpt ? altTick[appliedAlt_q] : internalTick;
    // Switch only on a boundary of the old source, or while stopped, so no period is cut short
    assign takeNew = !timerRun || curTick;

    // ----------------------------------------------------------------
    // Applied selection and tick register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            appliedSel <= 3'h0;
            appliedOpt <= 1'b0;
            appliedAlt_q <= 2'h0;
            countTick <= 1'b0;
        end else begin
            countTick <= curTick;
            if (takeNew) begin
                appliedSel <= reqSel;
                appliedOpt <= reqOpt;
                appliedAlt_q <= reqAlt;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_div32_pick;
        @(posedge clock) disable iff (!rst_b)
        (!appliedOpt && appliedSel == 3'b010 && div32Tick) |=> countTick;
    endproperty
    a_div32_pick: assert property (p_div32_pick) else $error("div32 tick lost");

    property p_sub_pick;
        @(posedge clock) disable iff (!rst_b)
        (!appliedOpt && appliedSel == 3'b110) |-> (sub32kTick == curTick);
    endproperty
    a_sub_pick: assert property (p_sub_pick) else $error("subclock not routed");

    property p_alt_over;
        @(posedge clock) disable iff (!rst_b)
        appliedOpt |=> (countTick == $past(altTick[appliedAlt_q]));
    endproperty
    a_alt_over: assert property (p_alt_over) else $error("alt field not obeyed");

    property p_base_pick;
        @(posedge clock) disable iff (!rst_b)
        (!appliedOpt && appliedSel == 3'b000 && !baseTick) |=> !countTick;
    endproperty
    a_base_pick: assert property (p_base_pick) else $error("base tick wrong");

    sequence s_running_quiet;
        timerRun && !curTick;
    endsequence
    property p_no_runt;
        @(posedge clock) disable iff (!rst_b)
        s_running_quiet |=> ($stable(appliedSel) && $stable(appliedOpt));
    endproperty
    a_no_runt: assert property (p_no_runt) else $error("source switched mid period");
endmodule

// *** hdl/tbcs_count_source_select.sv ***
// Timer count source select: APB registers, prescaler and six source multiplexers
module tbcs_count_source_select (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Slow clock ticks, one cycle each
    input wire logic slowOscTick,
    input wire logic sub32kTick,
    input wire logic [3:0] altTick,
    // Timers
    input wire logic [5:0] timerRun,
    output logic [5:0] countTick
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] pairA_q;
    logic [7:0] pairAExt_q;
    logic [7:0] pairB_q;
    logic [7:0] pairBExt_q;
    logic prescaleHalve_q;
    logic [11:0] altSrc_q;
    logic [5:0] preCnt_q;
    logic [2:0] wdHist_q;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic accessPh;
    logic wrEn;
    logic hitA;
    logic hitAExt;
    logic hitB;
    logic hitBExt;
    logic hitPer;
    logic hitAlt;
    logic hitApp;
    logic mapped;
    logic [31:0] rdMux;
    logic [23:0] appliedVec;
    assign accessPh = psel && penable;
    // One wait state lets read data come from a flop; writes land at the pready edge
    assign wrEn = accessPh && pready && pwrite;
    assign hitA = paddr == tbcs_pkg::OFF_PAIR_A;
    assign hitAExt = paddr == tbcs_pkg::OFF_PAIR_A_EXT;
    assign hitB = paddr == tbcs_pkg::OFF_PAIR_B;
    assign hitBExt = paddr == tbcs_pkg::OFF_PAIR_B_EXT;
    assign hitPer = paddr == tbcs_pkg::OFF_PERIPH_CLK;
    assign hitAlt = paddr == tbcs_pkg::OFF_ALT_SRC;
    assign hitApp = paddr == tbcs_pkg::OFF_APPLIED;
    assign mapped = hitA | hitAExt | hitB | hitBExt | hitPer | hitAlt | hitApp;
    assign rdMux = hitA ? {24'h000000, pairA_q} :
                   hitAExt ? {24'h000000, pairAExt_q} :
                   hitB ? {24'h000000, pairB_q} :
                   hitBExt ? {24'h000000, pairBExt_q} :
                   hitPer ? {31'h0, prescaleHalve_q} :
                   hitAlt ? {20'h00000, altSrc_q} :
                   hitApp ? {8'h00, appliedVec} : 32'h00000000;

    // Bus handshake and read capture
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= accessPh && !pready;
            pslverr <= accessPh && !pready && !mapped;
            if (accessPh && !pready) begin
                prdata <= pwrite ? 32'h00000000 : rdMux;
            end
        end
    end

    // Register writes; the applied-selection word is read only
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pairA_q <= tbcs_pkg::SEL_REG_RST;
            pairAExt_q <= tbcs_pkg::SEL_REG_RST;
            pairB_q <= tbcs_pkg::SEL_REG_RST;
            pairBExt_q <= tbcs_pkg::SEL_REG_RST;
            prescaleHalve_q <= tbcs_pkg::PERIPH_CLK_RST;
            altSrc_q <= tbcs_pkg::ALT_SRC_RST;
        end else if (wrEn) begin
            if (hitA) pairA_q <= pwdata[7:0];
            if (hitAExt) pairAExt_q <= pwdata[7:0];
            if (hitB) pairB_q <= pwdata[7:0];
            if (hitBExt) pairBExt_q <= pwdata[7:0];
            if (hitPer) prescaleHalve_q <= pwdata[tbcs_pkg::HALVE_BIT];
            if (hitAlt) altSrc_q <= pwdata[11:0];
        end
    end

    // ----------------------------------------------------------------
    // Prescaler: divide-by-N ticks from one free-running counter
    // ----------------------------------------------------------------
    logic baseTick;
    logic div8Tick;
    logic div32Tick;
    logic div64Tick;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            preCnt_q <= 6'h00;
        end else begin
            preCnt_q <= preCnt_q + 6'h01;
        end
    end
    // Undivided base ticks every cycle; halved base ticks on odd counts
    assign baseTick = !prescaleHalve_q ||
        ((preCnt_q & tbcs_pkg::PRE_DIV2_MASK) == tbcs_pkg::PRE_DIV2_MASK);
    assign div8Tick = (preCnt_q & tbcs_pkg::PRE_DIV8_MASK) == tbcs_pkg::PRE_DIV8_MASK;
    assign div32Tick = (preCnt_q & tbcs_pkg::PRE_DIV32_MASK) == tbcs_pkg::PRE_DIV32_MASK;
    assign div64Tick = (preCnt_q & tbcs_pkg::PRE_DIV64_MASK) == tbcs_pkg::PRE_DIV64_MASK;

    // ----------------------------------------------------------------
    // Per-timer selector fields
    // ----------------------------------------------------------------
    logic [2:0] reqSel [6];
    logic reqOpt [6];
    logic [2:0] appliedSel [6];
    logic appliedOpt [6];
    // Low half drives the lower-numbered timer of a pair, high half the higher one
    assign reqSel[0] = pairA_q[tbcs_pkg::LOW_SEL_LSB +: 3];
    assign reqOpt[0] = pairA_q[tbcs_pkg::LOW_OPT_BIT];
    assign reqSel[1] = pairA_q[tbcs_pkg::HIGH_SEL_LSB +: 3];
    assign reqOpt[1] = pairA_q[tbcs_pkg::HIGH_OPT_BIT];
    assign reqSel[2] = pairAExt_q[tbcs_pkg::LOW_SEL_LSB +: 3];
    assign reqOpt[2] = pairAExt_q[tbcs_pkg::LOW_OPT_BIT];
    assign reqSel[3] = pairB_q[tbcs_pkg::LOW_SEL_LSB +: 3];
    assign reqOpt[3] = pairB_q[tbcs_pkg::LOW_OPT_BIT];
    assign reqSel[4] = pairB_q[tbcs_pkg::HIGH_SEL_LSB +: 3];
    assign reqOpt[4] = pairB_q[tbcs_pkg::HIGH_OPT_BIT];
    assign reqSel[5] = pairBExt_q[tbcs_pkg::LOW_SEL_LSB +: 3];
    assign reqOpt[5] = pairBExt_q[tbcs_pkg::LOW_OPT_BIT];

    // ----------------------------------------------------------------
    // Source multiplexers, one per timer
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < tbcs_pkg::NUM_TIMERS; gi++) begin : g_mux
            tbcs_clk_mux u_mux (
                .clock(clock),
                .rst_b(rst_b),
                .reqSel(reqSel[gi]),
                .reqOpt(reqOpt[gi]),
                .reqAlt(altSrc_q[gi*tbcs_pkg::ALT_FIELD_W +: tbcs_pkg::ALT_FIELD_W]),
                .baseTick(baseTick),
                .div8Tick(div8Tick),
                .div32Tick(div32Tick),
                .div64Tick(div64Tick),
                .slowOscTick(slowOscTick),
                .sub32kTick(sub32kTick),
                .altTick(altTick),
                .timerRun(timerRun[gi]),
                .countTick(countTick[gi]),
                .appliedSel(appliedSel[gi]),
                .appliedOpt(appliedOpt[gi])
            );
            assign appliedVec[gi*tbcs_pkg::APPLIED_FIELD_W +: tbcs_pkg::APPLIED_FIELD_W] =
                {appliedOpt[gi], appliedSel[gi]};
        end
    endgenerate

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic wrPairB;
    assign wrPairB = wrEn && hitB;
    // Remembers the high-half selector of the last pair B write
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wdHist_q <= 3'h0;
        end else if (wrPairB) begin
            wdHist_q <= pwdata[6:4];
        end
    end

    sequence s_wr_b_stopped;
        (wrPairB && !timerRun[4]) ##1 !timerRun[4];
    endsequence
    property p_pair_b_high;
        @(posedge clock) disable iff (!rst_b)
        s_wr_b_stopped |=> (appliedSel[4] == wdHist_q);
    endproperty
    a_pair_b_high: assert property (p_pair_b_high) else $error("timer 4 select wrong");

    property p_pair_a_low;
        @(posedge clock) disable iff (!rst_b)
        (wrEn && hitA && !timerRun[0]) ##1 !timerRun[0] |=>
            (appliedOpt[0] == pairA_q[tbcs_pkg::LOW_OPT_BIT]);
    endproperty
    a_pair_a_low: assert property (p_pair_a_low) else $error("timer 0 option wrong");

    property p_halve;
        @(posedge clock) disable iff (!rst_b)
        (prescaleHalve_q && baseTick) |=> (!baseTick || !prescaleHalve_q);
    endproperty
    a_halve: assert property (p_halve) else $error("base clock not halved");

    property p_full_rate;
        @(posedge clock) disable iff (!rst_b)
        !prescaleHalve_q |-> baseTick;
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("base clock not full rate");
endmodule

// *** hdl/tbcs_pkg.sv ***
// Package: register map, field layout and prescaler constants for timer source select
package tbcs_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_PAIR_A = 8'h00;
    localparam logic [7:0] OFF_PAIR_A_EXT = 8'h04;
    localparam logic [7:0] OFF_PAIR_B = 8'h08;
    localparam logic [7:0] OFF_PAIR_B_EXT = 8'h0c;
    localparam logic [7:0] OFF_PERIPH_CLK = 8'h10;
    localparam logic [7:0] OFF_ALT_SRC = 8'h14;
    localparam logic [7:0] OFF_APPLIED = 8'h18;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int LOW_SEL_LSB = 0;
    localparam int LOW_OPT_BIT = 3;
    localparam int HIGH_SEL_LSB = 4;
    localparam int HIGH_OPT_BIT = 7;
    localparam int HALVE_BIT = 0;
    localparam int ALT_FIELD_W = 2;
    localparam int APPLIED_FIELD_W = 4;
    localparam logic [7:0] SEL_REG_RST = 8'h00;
    localparam logic [11:0] ALT_SRC_RST = 12'h000;
    localparam logic PERIPH_CLK_RST = 1'b0;

    // ----------------------------------------------------------------
    // Count source codes of the 3-bit selector
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_BASE = 3'b000,
        SRC_DIV8 = 3'b001,
        SRC_DIV32 = 3'b010,
        SRC_DIV64 = 3'b011,
        SRC_RSVD4 = 3'b100,
        SRC_SLOW_OSC = 3'b101,
        SRC_SUB32K = 3'b110,
        SRC_RSVD7 = 3'b111
    } tbcs_src_e;

    // ----------------------------------------------------------------
    // Prescaler terminal counts (divide-by-N ticks)
    // ----------------------------------------------------------------
    localparam int PRE_W = 6;
    localparam logic [5:0] PRE_DIV2_MASK = 6'h01;
    localparam logic [5:0] PRE_DIV8_MASK = 6'h07;
    localparam logic [5:0] PRE_DIV32_MASK = 6'h1f;
    localparam logic [5:0] PRE_DIV64_MASK = 6'h3f;
    localparam int NUM_TIMERS = 6;
endpackage

// *** tb/tb_tbcs_count_source_select.sv ***
// Testbench: register access and count source selection checks for the timer source select
module tb_tbcs_count_source_select;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Signals and expectation tables
    // ----------------------------------------------------------------
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic slowOscTick = 1'b0;
    logic sub32kTick = 1'b0;
    logic [3:0] altTick = 4'h0;
    logic quiet = 1'b0;
    logic [5:0] timerRun = 6'h00;
    logic [5:0] countTick;
    int cyc = 0;
    int miscompares = 0;
    int checksDone = 0;
    int cnt[6];
    logic [31:0] rdat;
    logic rerr;
    // Ticks per 192-cycle window for each selector code; periods chosen so no two collide
    int codeCnt[8] = '{192, 24, 6, 3, 0, 16, 4, 0};
    int altPer[4] = '{3, 4, 6, 24};
    int altCnt[4] = '{64, 48, 32, 8};
    int mixCnt[6] = '{24, 4, 3, 24, 6, 16};

    tbcs_count_source_select tbcs_count_source_select_i (
        .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slowOscTick(slowOscTick), .sub32kTick(sub32kTick), .altTick(altTick),
        .timerRun(timerRun), .countTick(countTick)
    );

    // Clock at 125 MHz
    always #4 clock = ~clock;

    // Slow sources as free-running pulse trains whose periods divide the count window
    always @(posedge clock) begin
        cyc <= cyc + 1;
        slowOscTick <= (cyc % 12) == 0;
        // Quiet holds the subclock still so a running timer sees no source boundary
        sub32kTick <= !quiet && ((cyc % 48) == 0);
        for (int k = 0; k < 4; k++) begin
            altTick[k] <= (cyc % altPer[k]) == 0;
        end
    end

    // ----------------------------------------------------------------
    // Compare, bus and counting tasks
    // ----------------------------------------------------------------
    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t ns: value %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chkn(input int got, input int exp);
        checksDone++;
        if (got != exp) begin
            miscompares++;
            $display("[FAIL] %0t ns: tick count %0d, expected %0d", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            miscompares++;
            $display("[FAIL] %0t ns: no ready from slave", $time);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chkv(rdat, exp);
        chkv({31'h0, rerr}, {31'h0, err});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(1'b1, a, d);
        chkv({31'h0, rerr}, {31'h0, err});
    endtask

    // Settle a few cycles, then count each timer's pulses over 192 cycles
    task automatic count_all();
        foreach (cnt[k]) cnt[k] = 0;
        repeat (4) @(posedge clock);
        repeat (192) begin
            @(posedge clock);
            for (int k = 0; k < 6; k++) begin
                if (countTick[k] === 1'b1) cnt[k]++;
            end
        end
    endtask

    task automatic final_report();
        $display("Checks made %0d, mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog sized well above the roughly 3400 cycles the tests need
    initial begin
        #200000;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        miscompares++;
        final_report();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        for (int a = 0; a < 7; a++) begin
            rd(8'(a * 4), 32'h0, 1'b0);
        end
        rd(8'h1c, 32'h0, 1'b1);
        wr(8'h1c, 32'hff, 1'b1);
        wr(tbcs_pkg::OFF_APPLIED, 32'hffffffff, 1'b0);
        rd(tbcs_pkg::OFF_APPLIED, 32'h0, 1'b0);
        $display("Test reset_and_map done");
        // Every legal low code on timer 0; reserved codes are never written
        for (int c = 0; c < 8; c++) begin
            if (c == 4 || c == 7) continue;
            wr(tbcs_pkg::OFF_PAIR_A, 32'(c), 1'b0);
            count_all();
            chkn(cnt[0], codeCnt[c]);
            rd(tbcs_pkg::OFF_APPLIED, 32'(c), 1'b0);
        end
        $display("Test low_codes done");
        for (int c = 0; c < 8; c++) begin
            if (c == 4 || c == 7) continue;
            wr(tbcs_pkg::OFF_PAIR_A, 32'(c) << 4, 1'b0);
            count_all();
            chkn(cnt[1], codeCnt[c]);
            chkn(cnt[0], 192);
            rd(tbcs_pkg::OFF_APPLIED, 32'(c) << 4, 1'b0);
        end
        $display("Test high_codes done");
        // Running timer keeps its held subclock source until that source ticks again
        quiet <= 1'b1;
        wr(tbcs_pkg::OFF_PAIR_A, 32'h06, 1'b0);
        timerRun <= 6'h01;
        wr(tbcs_pkg::OFF_PAIR_A, 32'h01, 1'b0);
        count_all();
        chkn(cnt[0], 0);
        rd(tbcs_pkg::OFF_APPLIED, 32'h6, 1'b0);
        rd(tbcs_pkg::OFF_PAIR_A, 32'h1, 1'b0);
        quiet <= 1'b0;
        repeat (60) @(posedge clock);
        rd(tbcs_pkg::OFF_APPLIED, 32'h1, 1'b0);
        timerRun <= 6'h00;
        $display("Test change_while_running done");
        wr(tbcs_pkg::OFF_PERIPH_CLK, 32'h1, 1'b0);
        wr(tbcs_pkg::OFF_PAIR_A, 32'h0, 1'b0);
        count_all();
        chkn(cnt[0], 96);
        chkn(cnt[1], 96);
        rd(tbcs_pkg::OFF_PERIPH_CLK, 32'h1, 1'b0);
        wr(tbcs_pkg::OFF_PERIPH_CLK, 32'h0, 1'b0);
        $display("Test halved_base done");
        // Option bits set, with nonzero selectors on timers 0 and 1 that must be ignored
        wr(tbcs_pkg::OFF_ALT_SRC, 32'h4e4, 1'b0);
        wr(tbcs_pkg::OFF_PAIR_A, 32'hd9, 1'b0);
        wr(tbcs_pkg::OFF_PAIR_A_EXT, 32'h08, 1'b0);
        wr(tbcs_pkg::OFF_PAIR_B, 32'h88, 1'b0);
        wr(tbcs_pkg::OFF_PAIR_B_EXT, 32'h08, 1'b0);
        timerRun <= 6'h3f;
        count_all();
        for (int k = 0; k < 6; k++) begin
            chkn(cnt[k], altCnt[k % 4]);
        end
        rd(tbcs_pkg::OFF_APPLIED, 32'h008888d9, 1'b0);
        timerRun <= 6'h00;
        $display("Test alternate_source done");
        wr(tbcs_pkg::OFF_PAIR_A, 32'h61, 1'b0);
        wr(tbcs_pkg::OFF_PAIR_A_EXT, 32'h03, 1'b0);
        wr(tbcs_pkg::OFF_PAIR_B, 32'h21, 1'b0);
        wr(tbcs_pkg::OFF_PAIR_B_EXT, 32'h05, 1'b0);
        count_all();
        for (int k = 0; k < 6; k++) begin
            chkn(cnt[k], mixCnt[k]);
        end
        rd(tbcs_pkg::OFF_APPLIED, 32'h00521361, 1'b0);
        rd(tbcs_pkg::OFF_ALT_SRC, 32'h4e4, 1'b0);
        $display("Test pair_routing done");
        final_report();
    end
endmodule
